// file: input_sync.v
// Purpose: three-stage synchroniser with agreement filter for one pin
// Assumes: pin is asynchronous to pclk
// Notes: output changes only when stages two and three agree
`timescale 1ns/100ps
module input_sync (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // pin and synchronised level
    input wire pin,
    output reg level
);
    reg meta;
    reg stage2;
    reg stage3;

    // meta is read only by stage2
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level <= 1'b0;
        end else begin
            meta <= pin;
            stage2 <= meta;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end
endmodule

// file: power_stage_model.sv
// Purpose: power stage answering the monitor's enable
// Assumes: pins cut power directly, bypassing the monitor
// Notes: stuck keeps power live to inject a channel failure
`timescale 1ns/100ps
module power_stage_model (
    // clock
    input wire pclk,
    // control and pins
    input wire enable,
    input wire pin_a,
    input wire pin_b,
    input wire stuck,
    // status
    output logic live
);
    initial live = 1'b0;
    // raw pins act before the monitor's synchroniser sees them
    always @(posedge pclk) begin
        live <= stuck | (enable & pin_a & pin_b);
    end
endmodule

// file: safe_torque_off_monitor.v
// Purpose: safe torque off status and fault monitor with APB registers
// Assumes: safety inputs active high; power stage status from driver
// Notes: presetn is the power-up reset and the only way to clear failure
// Summary of operation
// RL1 - enabled flag follows live power stage
// RL2 - fault on overtemp, overcurrent or torque cut
// RL3 - fault while either safety input inactive
// RL4 - fault clears itself when causes vanish
// RL5 - enable refused while fault high
// RL6 - level a mirrors safety input a
// RL7 - level b mirrors safety input b
// RL8 - cut flag set when any input inactive
// RL9 - cut flag clears when both inputs active
// RL10 - failure when input inactive, stage live
// RL11 - failure on mismatch time limit fault
// RL12 - failure disables stage, refuses moves
// RL13 - failure latched until power-up reset
// RL14 - mismatch checks armed for 50..3000 ms
// RL15 - failure when inputs differ past limit
// RL16 - failure when input toggles twice quickly
// RL17 - zero limit disables mismatch checks
// RL18 - module lamp flash alone: nvm write failed
// RL19 - both lamps flash: address/protocol changed
// RL20 - synchronise inputs, time with ms tick
`timescale 1ns/100ps
`include "sto_monitor_consts.vh"
module safe_torque_off_monitor (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // safety input pins
    input wire safety_input_a,
    input wire safety_input_b,
    // power stage
    input wire stage_live,
    input wire over_temperature,
    input wire over_current,
    input wire nvm_write_failed,
    input wire address_changed,
    output reg stage_enable,
    output wire move_allowed,
    // lamps
    output reg module_status_lamp,
    output reg network_status_lamp
);
    wire level_a;
    wire level_b;
    reg [1:0] control;
    reg [11:0] limit;
    reg [15:0] tick_count;
    reg tick;
    reg [11:0] diff_ms;
    reg [11:0] since_a_ms;
    reg [11:0] since_b_ms;
    reg prev_a;
    reg prev_b;
    reg seen_a;
    reg seen_b;
    reg safety_channel_failure;
    reg [23:0] flash_count;
    reg flash;
    wire armed;
    wire inputs_differ;
    wire edge_a;
    wire edge_b;
    wire mismatch_fault;
    wire torque_cut_flag;
    wire power_stage_fault;
    wire drive_enabled_flag;
    wire [31:0] status_word;
    wire wr_en;
    wire rd_en;

    // three flops and agreement on each safety pin
    input_sync sync_a ( // RL20
        .pclk(pclk),
        .presetn(presetn),
        .pin(safety_input_a),
        .level(level_a)
    );
    input_sync sync_b ( // RL20
        .pclk(pclk),
        .presetn(presetn),
        .pin(safety_input_b),
        .level(level_b)
    );

    assign torque_cut_flag = ~(level_a & level_b); // RL8 RL9
    assign power_stage_fault = over_temperature | over_current
        | torque_cut_flag; // RL2 RL3 RL4
    assign drive_enabled_flag = stage_live; // RL1

    // limits outside the programmed range leave the checks off
    assign armed = (limit >= `LIMIT_MIN_MS) &&
        (limit <= `LIMIT_MAX_MS); // RL14 RL17
    assign inputs_differ = level_a ^ level_b;
    assign edge_a = level_a ^ prev_a;
    assign edge_b = level_b ^ prev_b;
    assign mismatch_fault = armed && ( // RL11
        (inputs_differ && tick && diff_ms >= limit) || // RL15
        (edge_a && seen_a && since_a_ms < limit) || // RL16
        (edge_b && seen_b && since_b_ms < limit)); // RL16

    // millisecond tick
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_count <= 16'h0000;
            tick <= 1'b0;
        end else if (tick_count == `TICK_CYCLES - 1) begin
            tick_count <= 16'h0000;
            tick <= 1'b1; // RL20
        end else begin
            tick_count <= tick_count + 16'h0001;
            tick <= 1'b0;
        end
    end

    // mismatch and toggle timers, saturate at the top of range
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diff_ms <= 12'h000;
            since_a_ms <= 12'h000;
            since_b_ms <= 12'h000;
            prev_a <= 1'b0;
            prev_b <= 1'b0;
            seen_a <= 1'b0;
            seen_b <= 1'b0;
        end else begin
            prev_a <= level_a;
            prev_b <= level_b;
            if (!inputs_differ) begin
                diff_ms <= 12'h000;
            end else if (tick && diff_ms != 12'hFFF) begin
                diff_ms <= diff_ms + 12'h001; // RL15
            end
            if (edge_a) begin
                since_a_ms <= 12'h000;
                seen_a <= 1'b1;
            end else if (tick && since_a_ms != 12'hFFF) begin
                since_a_ms <= since_a_ms + 12'h001; // RL16
            end
            if (edge_b) begin
                since_b_ms <= 12'h000;
                seen_b <= 1'b1;
            end else if (tick && since_b_ms != 12'hFFF) begin
                since_b_ms <= since_b_ms + 12'h001; // RL16
            end
        end
    end

    // latched failure: no bus path clears it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            safety_channel_failure <= 1'b0; // RL13
        end else if ((torque_cut_flag && stage_live) // RL10
            || mismatch_fault) begin // RL11
            safety_channel_failure <= 1'b1;
        end
    end

    // stage enable follows the request only with no fault or failure
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_enable <= 1'b0;
        end else begin
            stage_enable <= control[`CT_ENABLE_REQ] & ~power_stage_fault
                & ~safety_channel_failure; // RL5 RL12
        end
    end
    assign move_allowed = control[`CT_MOVE_REQ] & stage_enable
        & ~safety_channel_failure; // RL12

    // lamp flash about 3 Hz
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_count <= 24'h000000;
            flash <= 1'b0;
            module_status_lamp <= 1'b0;
            network_status_lamp <= 1'b0;
        end else begin
            if (flash_count == 24'h7A11FF) begin
                flash_count <= 24'h000000;
                flash <= ~flash;
            end else begin
                flash_count <= flash_count + 24'h000001;
            end
            // address change wins: both lamps flash together
            module_status_lamp <= (nvm_write_failed | address_changed)
                & flash; // RL18 RL19
            network_status_lamp <= address_changed & flash; // RL19
        end
    end

    // apb: zero wait states, no error response
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= 2'b00;
            limit <= `LIMIT_RESET;
        end else if (wr_en) begin
            if (paddr == `ADDR_CONTROL) begin
                control <= pwdata[1:0];
            end else if (paddr == `ADDR_LIMIT) begin
                limit <= pwdata[11:0];
            end
        end
    end

    assign status_word = {25'h0000000,
        move_allowed,
        safety_channel_failure,
        torque_cut_flag,
        level_b, // RL7
        level_a, // RL6
        power_stage_fault,
        drive_enabled_flag};

    // read data captured in setup, held through access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            if (paddr == `ADDR_STATUS) begin
                prdata <= status_word;
            end else if (paddr == `ADDR_CONTROL) begin
                prdata <= {30'h00000000, control};
            end else if (paddr == `ADDR_LIMIT) begin
                prdata <= {20'h00000, limit};
            end else if (paddr == `ADDR_LAMPS) begin
                prdata <= {30'h00000000, address_changed, nvm_write_failed};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end
endmodule

// file: safe_torque_off_monitor_test.sv
// Purpose: self-checking bench for the torque off monitor
// Assumes: zero-wait apb slave, inputs settle within 12 cycles
// Notes: the differ-past-limit check needs at least 50 ms of run, left to later work; quick toggles are checked
`timescale 1ns/100ps
`include "sto_monitor_consts.vh"
module safe_torque_off_monitor_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, r;
    logic pa, pb, ot, oc, nv, ac, stk, live, en, mv;
    int miscompares, checks, cycles;

    safe_torque_off_monitor uut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .safety_input_a(pa), .safety_input_b(pb), .stage_live(live),
        .over_temperature(ot), .over_current(oc), .nvm_write_failed(nv),
        .address_changed(ac), .stage_enable(en), .move_allowed(mv),
        .module_status_lamp(), .network_status_lamp());
    power_stage_model ps (.pclk, .enable(en), .pin_a(pa), .pin_b(pb),
        .stuck(stk), .live);

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // idle cycle after each transfer avoids double drive of psel
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
        check({31'h0, pslverr}, 32'h0);
    endtask
    function logic [31:0] exp_st(input logic a, b, t, c);
        logic f;
        f = t | c | !a | !b;
        return {25'h0, !f, 1'b0, !a | !b, b, a, f, !f};
    endfunction
    task wrap_up;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {pa, pb, ot, oc, nv, ac, stk} = 7'b1100000;
        r = $urandom(54);
        wt(8);
        presetn <= 1'b1;
        wt(8);
        rdchk(`ADDR_STATUS, 32'h0000000C);
        rdchk(`ADDR_CONTROL, 32'h0);
        rdchk(`ADDR_LIMIT, 32'h0);
        rdchk(12'h010, 32'h0);
        apb(1'b1, `ADDR_STATUS, 32'hFFFFFFFF);
        rdchk(`ADDR_STATUS, 32'h0000000C);
        apb(1'b1, `ADDR_LIMIT, 32'h00000032);
        rdchk(`ADDR_LIMIT, 32'h00000032);
        // just below the armed range, so random toggles stay legal
        apb(1'b1, `ADDR_LIMIT, 32'h00000031);
        apb(1'b1, `ADDR_CONTROL, 32'h3);
        wt(12);
        rdchk(`ADDR_STATUS, 32'h0000004D);
        for (int i = 0; i < 40; i++) begin
            if (i == 20) apb(1'b1, `ADDR_LIMIT, 32'h0);
            r = $urandom;
            {pa, pb} <= r[1:0] | r[5:4];
            {ot, oc} <= r[3:2] & r[7:6];
            {nv, ac} <= r[9:8];
            wt(12);
            rdchk(`ADDR_STATUS, exp_st(pa, pb, ot, oc));
            rdchk(`ADDR_LAMPS, {30'h0, ac, nv});
        end
        {pa, pb, ot, oc} <= 4'b1100;
        wt(12);
        stk <= 1'b1;
        wt(2);
        pb <= 1'b0;
        wt(12);
        rdchk(`ADDR_STATUS, 32'h00000037);
        check({31'h0, en | mv}, 32'h0);
        stk <= 1'b0;
        pb <= 1'b1;
        apb(1'b1, `ADDR_CONTROL, 32'h3);
        wt(12);
        rdchk(`ADDR_STATUS, 32'h0000002C);
        presetn <= 1'b0;
        wt(2);
        presetn <= 1'b1;
        wt(8);
        rdchk(`ADDR_STATUS, 32'h0000000C);
        // armed limit: one quick low pulse on a is two edges well inside it
        apb(1'b1, `ADDR_LIMIT, 32'h00000032);
        pa <= 1'b0;
        wt(12);
        pa <= 1'b1;
        wt(12);
        rdchk(`ADDR_STATUS, 32'h0000002C);
        wrap_up();
    end
endmodule

// file: sto_mon_chk.sv
// Purpose: port checks for the torque off monitor
// Assumes: one pclk domain
// Notes: bound to every monitor instance
`timescale 1ns/100ps
module sto_mon_chk (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // watched ports
    input wire safety_input_a,
    input wire safety_input_b,
    input wire stage_live,
    input wire over_temperature,
    input wire over_current,
    input wire address_changed,
    input wire nvm_write_failed,
    input wire stage_enable,
    input wire move_allowed,
    input wire module_status_lamp,
    input wire network_status_lamp
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_move_needs_on: assert property (move_allowed |-> stage_enable)
        else $error("move allowed with stage off");
    chk_heat_blocks: assert property (
        over_temperature [*4] |-> !stage_enable) else $error("hot but on");
    chk_amps_blocks: assert property (
        over_current [*4] |-> !stage_enable) else $error("overcurrent on");
    chk_in_a_blocks: assert property (
        !safety_input_a [*8] |-> !stage_enable) else $error("a low but on");
    chk_in_b_blocks: assert property (
        !safety_input_b [*8] |-> !stage_enable) else $error("b low but on");
    chk_live_fail: assert property (
        (stage_live && !safety_input_b) [*8] |=> !stage_enable [*8])
        else $error("live stage with b low not shut");
    chk_module_quiet: assert property (
        (!nvm_write_failed && !address_changed) [*8] |-> !module_status_lamp)
        else $error("module lamp without cause");
    chk_net_quiet: assert property (
        !address_changed [*8] |-> !network_status_lamp)
        else $error("network lamp without cause");
    cover property ($rose(stage_enable));
    cover property (move_allowed);
    cover property (stage_live && !safety_input_b);
endmodule

bind safe_torque_off_monitor sto_mon_chk u_chk (.pclk, .presetn,
    .safety_input_a, .safety_input_b, .stage_live, .over_temperature,
    .over_current, .address_changed, .nvm_write_failed, .stage_enable,
    .move_allowed, .module_status_lamp, .network_status_lamp);

// file: sto_monitor_consts.vh
// Purpose: constants for the safe torque off monitor
// Assumes: 50 MHz pclk, APB with 32-bit data
// Notes: offsets are byte addresses
`ifndef STO_MONITOR_CONSTS_VH
`define STO_MONITOR_CONSTS_VH

`define ADDR_STATUS 12'h000
`define ADDR_CONTROL 12'h004
`define ADDR_LIMIT 12'h008
`define ADDR_LAMPS 12'h00C

// status register fields
`define ST_ENABLED 0
`define ST_FAULT 1
`define ST_LEVEL_A 2
`define ST_LEVEL_B 3
`define ST_CUT 4
`define ST_FAILURE 5
`define ST_MOVE_OK 6

// control register fields
`define CT_ENABLE_REQ 0
`define CT_MOVE_REQ 1

// lamp register fields
`define LP_NVM_FAIL 0
`define LP_ADDR_CHANGED 1

`define LIMIT_RESET 12'h000
`define LIMIT_MIN_MS 12'h032
`define LIMIT_MAX_MS 12'hBB8

// millisecond tick: 1 ms at 20 ns per cycle
`define TICK_PERIOD_NS 1000000
`define CLK_PERIOD_NS 20
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

`endif
